// [include/mode_ctl_pkg.sv]
`default_nettype none
package mode_ctl_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned WINDOW_MS = 5000;
    localparam int unsigned HALF_S_MS = 500;
    localparam int unsigned LONG_PRESS_MS = 5000;
    localparam int unsigned LAMP_AMBER_MS = 250;
    localparam int unsigned LAMP_GREEN_MS = 250;
    localparam int unsigned NET_RESET_MS = 10;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_IRQ_EN = 32'h0000_000C;
    localparam logic [31:0] ADDR_IRQ_CLR = 32'h0000_0010;
    localparam int unsigned CTRL_SW_EN = 0;
    localparam int unsigned CTRL_PROT_EN = 1;
    localparam int unsigned CTRL_PORT_LM = 2;
    localparam int unsigned CTRL_FATAL = 3;
    localparam int unsigned CTRL_NONFATAL = 4;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned EV_FAULT_CLR = 0;
    localparam int unsigned EV_SHORT = 1;
    localparam int unsigned EV_LONG = 2;
    localparam int unsigned EV_WIN_END = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [design/input_debounce.sv]
`default_nettype none
module input_debounce (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ms_tick,
    input wire logic i_raw,
    output logic o_level
);
    logic sync1_ff;
    logic sync2_ff;
    logic [7:0] cnt_ff;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= i_raw;
            sync2_ff <= sync1_ff;
        end
    end

    // Level must hold steady for the whole debounce time
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_ff <= 8'h00;
            o_level <= 1'b0;
        end else if (sync2_ff == o_level) begin
            cnt_ff <= 8'h00;
        end else if (i_ms_tick) begin
            if (cnt_ff == 8'(mode_ctl_pkg::DEBOUNCE_MS - 1)) begin
                o_level <= sync2_ff;
                cnt_ff <= 8'h00;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [design/mode_switch_ctl.sv]
`default_nettype none
// How it works
// - With switch selection enabled, switch position chooses Run or Stop.
// - With protection enabled, switch in Stop blocks memory writes and forcing.
// - Reset leaves switch selection on and memory protection off.
// - Nonfatal faults only: Run position enters Run at once, faults kept.
// - Stop-faulted with fatal faults: Run position opens a 5 s blink window.
// - Run half second, Stop half second, Run again clears faults, enters Run.
// - Window expiry without toggle: indicator off, stay stop-faulted, faults kept.
// - Press under 5 s resets network, tests lamps, raises the short-press interrupt event.
// - Press of 5 s or more toggles serial port into forced local management.
// - Port configured for local management is never toggled to controller protocols.
// - Forced port mode lasts until power cycle or next long press.
// - Lamp test shows network lamps amber briefly, then green.
module mode_switch_ctl #(
    parameter int unsigned MS_CYCLES = mode_ctl_pkg::MS_CYCLES
) (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_SW_RUN,
    input wire logic I_RESTART_BTN,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic O_RUN_MODE,
    output logic O_RUN_LED,
    output logic O_FAULT_CLEAR,
    output logic O_MEM_WRITE_BLOCK,
    output logic O_FORCE_BLOCK,
    output logic O_NET_RESET,
    output logic O_NET_LED_AMBER,
    output logic O_NET_LED_GREEN,
    output logic O_PORT_LOCAL_MGR,
    output logic O_IRQ
);
    typedef enum logic [4:0] {
        ST_STOP = 5'h01,
        ST_RUN = 5'h02,
        ST_WIN_RUN = 5'h04,
        ST_WIN_STOP = 5'h08,
        ST_FAULTED = 5'h10
    } mode_t;

    typedef enum logic [3:0] {
        NS_IDLE = 4'h1,
        NS_RESET = 4'h2,
        NS_AMBER = 4'h4,
        NS_GREEN = 4'h8
    } net_t;

    logic [15:0] pre_ff;
    logic ms_tick;
    logic sw_run;
    logic btn;
    logic [4:0] ctrl_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_en_ff;
    logic [3:0] ev;
    mode_t mode_ff;
    logic [12:0] win_ms_ff;
    logic [12:0] hold_ms_ff;
    logic [12:0] press_ms_ff;
    logic btn_d_ff;
    logic long_done_ff;
    logic forced_ff;
    net_t net_ff;
    logic [12:0] net_ms_ff;
    logic [7:0] blink_ms_ff;
    logic blink_ff;
    logic aw_ok_ff;
    logic w_ok_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_fire;
    logic sw_en;
    logic short_ev;
    logic long_ev;
    logic win_end;
    logic clr_ev;
    logic half_done;

    function automatic logic [12:0] ms(input int unsigned v);
        return 13'(v);
    endfunction

    // Millisecond timebase from the reference clock
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre_ff <= 16'h0000;
        end else if (pre_ff == 16'(MS_CYCLES - 1)) begin
            pre_ff <= 16'h0000;
        end else begin
            pre_ff <= pre_ff + 16'h0001;
        end
    end
    assign ms_tick = (pre_ff == 16'(MS_CYCLES - 1));

    input_debounce u_sw_db (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_ms_tick(ms_tick),
        .i_raw(I_SW_RUN),
        .o_level(sw_run)
    );

    input_debounce u_btn_db (
        .i_clk(I_REF_CLK),
        .i_arst_n(I_ARST_N),
        .i_ms_tick(ms_tick),
        .i_raw(I_RESTART_BTN),
        .o_level(btn)
    );

    assign sw_en = ctrl_ff[mode_ctl_pkg::CTRL_SW_EN];
    assign half_done = (hold_ms_ff >= ms(mode_ctl_pkg::HALF_S_MS));

    // Operating mode sequencer
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            mode_ff <= ST_STOP;
        end else if (!sw_en) begin
            mode_ff <= ST_STOP;
        end else begin
            unique case (mode_ff)
                ST_STOP: begin
                    if (sw_run && ctrl_ff[mode_ctl_pkg::CTRL_FATAL]) begin
                        mode_ff <= ST_WIN_RUN;
                    end else if (sw_run) begin
                        mode_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!sw_run) begin
                        mode_ff <= ST_STOP;
                    end
                end
                ST_WIN_RUN: begin
                    if (win_end) begin
                        mode_ff <= ST_FAULTED;
                    end else if (!sw_run && half_done) begin
                        mode_ff <= ST_WIN_STOP;
                    end
                end
                ST_WIN_STOP: begin
                    if (win_end) begin
                        mode_ff <= ST_FAULTED;
                    end else if (sw_run && half_done) begin
                        mode_ff <= ST_RUN;
                    end else if (sw_run) begin
                        mode_ff <= ST_WIN_RUN;
                    end
                end
                ST_FAULTED: begin
                    if (!sw_run) begin
                        mode_ff <= ST_STOP;
                    end
                end
            endcase
        end
    end

    assign clr_ev = (mode_ff == ST_WIN_STOP) && sw_run && half_done && !win_end && sw_en;
    assign win_end = (win_ms_ff == ms(mode_ctl_pkg::WINDOW_MS)) && ms_tick;

    // Blink window and per-position hold timers
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            win_ms_ff <= 13'h0000;
            hold_ms_ff <= 13'h0000;
        end else if (mode_ff != ST_WIN_RUN && mode_ff != ST_WIN_STOP) begin
            win_ms_ff <= 13'h0000;
            hold_ms_ff <= 13'h0000;
        end else begin
            if (ms_tick && win_ms_ff != ms(mode_ctl_pkg::WINDOW_MS)) begin
                win_ms_ff <= win_ms_ff + 13'h0001;
            end
            if (sw_run != (mode_ff == ST_WIN_RUN)) begin
                hold_ms_ff <= 13'h0000;
            end else if (ms_tick && !half_done) begin
                hold_ms_ff <= hold_ms_ff + 13'h0001;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            blink_ms_ff <= 8'h00;
            blink_ff <= 1'b0;
        end else if (ms_tick) begin
            if (blink_ms_ff == 8'(mode_ctl_pkg::BLINK_HALF_MS - 1)) begin
                blink_ms_ff <= 8'h00;
                blink_ff <= !blink_ff;
            end else begin
                blink_ms_ff <= blink_ms_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RUN_MODE <= 1'b0;
            O_RUN_LED <= 1'b0;
            O_FAULT_CLEAR <= 1'b0;
            O_MEM_WRITE_BLOCK <= 1'b0;
            O_FORCE_BLOCK <= 1'b0;
        end else begin
            O_RUN_MODE <= (mode_ff == ST_RUN);
            O_RUN_LED <= (mode_ff == ST_RUN) ||
                ((mode_ff == ST_WIN_RUN || mode_ff == ST_WIN_STOP) && blink_ff);
            O_FAULT_CLEAR <= clr_ev;
            O_MEM_WRITE_BLOCK <= ctrl_ff[mode_ctl_pkg::CTRL_PROT_EN] && !sw_run;
            O_FORCE_BLOCK <= ctrl_ff[mode_ctl_pkg::CTRL_PROT_EN] && !sw_run;
        end
    end

    // Press timing; long press is decided the moment 5 s is reached
    assign long_ev = btn && !long_done_ff && (press_ms_ff == ms(mode_ctl_pkg::LONG_PRESS_MS));
    assign short_ev = !btn && btn_d_ff && !long_done_ff;

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            press_ms_ff <= 13'h0000;
            btn_d_ff <= 1'b0;
            long_done_ff <= 1'b0;
        end else begin
            btn_d_ff <= btn;
            if (!btn) begin
                press_ms_ff <= 13'h0000;
                long_done_ff <= 1'b0;
            end else begin
                if (ms_tick && press_ms_ff != ms(mode_ctl_pkg::LONG_PRESS_MS)) begin
                    press_ms_ff <= press_ms_ff + 13'h0001;
                end
                if (long_ev) begin
                    long_done_ff <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            forced_ff <= 1'b0;
        end else if (long_ev && !ctrl_ff[mode_ctl_pkg::CTRL_PORT_LM]) begin
            forced_ff <= !forced_ff;
        end
    end

    // Local management by configuration always wins
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PORT_LOCAL_MGR <= 1'b0;
        end else begin
            O_PORT_LOCAL_MGR <= ctrl_ff[mode_ctl_pkg::CTRL_PORT_LM] || forced_ff;
        end
    end

    // Network restart: reset pulse, then amber, then green lamp test
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            net_ff <= NS_IDLE;
            net_ms_ff <= 13'h0000;
        end else if (short_ev) begin
            net_ff <= NS_RESET;
            net_ms_ff <= 13'h0000;
        end else if (ms_tick) begin
            net_ms_ff <= net_ms_ff + 13'h0001;
            unique case (net_ff)
                NS_IDLE: begin
                    net_ms_ff <= 13'h0000;
                end
                NS_RESET: begin
                    if (net_ms_ff == ms(mode_ctl_pkg::NET_RESET_MS - 1)) begin
                        net_ff <= NS_AMBER;
                        net_ms_ff <= 13'h0000;
                    end
                end
                NS_AMBER: begin
                    if (net_ms_ff == ms(mode_ctl_pkg::LAMP_AMBER_MS - 1)) begin
                        net_ff <= NS_GREEN;
                        net_ms_ff <= 13'h0000;
                    end
                end
                NS_GREEN: begin
                    if (net_ms_ff == ms(mode_ctl_pkg::LAMP_GREEN_MS - 1)) begin
                        net_ff <= NS_IDLE;
                        net_ms_ff <= 13'h0000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_NET_RESET <= 1'b0;
            O_NET_LED_AMBER <= 1'b0;
            O_NET_LED_GREEN <= 1'b0;
        end else begin
            O_NET_RESET <= (net_ff == NS_RESET);
            O_NET_LED_AMBER <= (net_ff == NS_AMBER);
            O_NET_LED_GREEN <= (net_ff == NS_GREEN);
        end
    end

    // AXI4-Lite write path
    assign S_AXI_AWREADY = !aw_ok_ff && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_ok_ff && !S_AXI_BVALID;
    assign wr_fire = aw_ok_ff && w_ok_ff;

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= mode_ctl_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_ok_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                unique case (awaddr_ff[7:0])
                    mode_ctl_pkg::ADDR_CTRL[7:0], mode_ctl_pkg::ADDR_IRQ_EN[7:0],
                    mode_ctl_pkg::ADDR_IRQ_CLR[7:0]: S_AXI_BRESP <= mode_ctl_pkg::RESP_OKAY;
                    default: S_AXI_BRESP <= mode_ctl_pkg::RESP_SLVERR;
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_ff <= mode_ctl_pkg::CTRL_RESET;
            irq_en_ff <= 4'h0;
        end else if (wr_fire && wstrb_ff[0]) begin
            if (awaddr_ff == mode_ctl_pkg::ADDR_CTRL) begin
                ctrl_ff <= wdata_ff[4:0];
            end
            if (awaddr_ff == mode_ctl_pkg::ADDR_IRQ_EN) begin
                irq_en_ff <= wdata_ff[3:0];
            end
        end else if (clr_ev) begin
            // Fault table cleared, fatal flag follows
            ctrl_ff[mode_ctl_pkg::CTRL_FATAL] <= 1'b0;
            ctrl_ff[mode_ctl_pkg::CTRL_NONFATAL] <= 1'b0;
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    assign ev = {win_end && sw_en, long_ev, short_ev, clr_ev};

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            irq_stat_ff <= 4'h0;
        end else if (wr_fire && wstrb_ff[0] && awaddr_ff == mode_ctl_pkg::ADDR_IRQ_CLR) begin
            irq_stat_ff <= (irq_stat_ff & ~wdata_ff[3:0]) | ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev;
        end
    end
    assign O_IRQ = |(irq_stat_ff & irq_en_ff);

    // AXI4-Lite read path
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= mode_ctl_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= mode_ctl_pkg::RESP_OKAY;
            unique case (S_AXI_ARADDR[7:0])
                mode_ctl_pkg::ADDR_CTRL[7:0]: S_AXI_RDATA <= {27'h0, ctrl_ff};
                mode_ctl_pkg::ADDR_STATUS[7:0]: S_AXI_RDATA <= {23'h0, net_ff, mode_ff};
                mode_ctl_pkg::ADDR_IRQ_STAT[7:0]: S_AXI_RDATA <= {28'h0, irq_stat_ff};
                mode_ctl_pkg::ADDR_IRQ_EN[7:0]: S_AXI_RDATA <= {28'h0, irq_en_ff};
                mode_ctl_pkg::ADDR_IRQ_CLR[7:0]: S_AXI_RDATA <= 32'h0000_0000;
                default: begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= mode_ctl_pkg::RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [dv/mode_switch_ctl_chk.sv]
`default_nettype none
module mode_switch_ctl_chk #(
    parameter int unsigned MS_CYCLES = mode_ctl_pkg::MS_CYCLES
) (
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    input wire logic I_SW_RUN,
    input wire logic I_RESTART_BTN,
    input wire logic O_RUN_MODE,
    input wire logic O_RUN_LED,
    input wire logic O_FAULT_CLEAR,
    input wire logic O_MEM_WRITE_BLOCK,
    input wire logic O_FORCE_BLOCK,
    input wire logic O_NET_RESET,
    input wire logic O_NET_LED_AMBER,
    input wire logic O_NET_LED_GREEN,
    input wire logic O_PORT_LOCAL_MGR
);
    // Tick phase is unknown, so the network reset length gets one tick of slack each way, the stray run time three
    localparam int NET_MIN = (mode_ctl_pkg::NET_RESET_MS - 1) * MS_CYCLES;
    localparam int NET_MAX = (mode_ctl_pkg::NET_RESET_MS + 1) * MS_CYCLES;
    localparam int STRAY_MAX = (mode_ctl_pkg::DEBOUNCE_MS + 3) * MS_CYCLES;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic [31:0] net_ff;
    logic [31:0] stray_ff;
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            net_ff <= 32'h0;
        end else begin
            net_ff <= O_NET_RESET ? net_ff + 32'h1 : 32'h0;
        end
    end
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            stray_ff <= 32'h0;
        end else begin
            stray_ff <= (O_RUN_MODE && !I_SW_RUN) ? stray_ff + 32'h1 : 32'h0;
        end
    end
    AST_BLOCK_PAIR: assert property (O_MEM_WRITE_BLOCK == O_FORCE_BLOCK)
        else $error("write and force blocks differ");
    AST_FC_ONE: assert property (O_FAULT_CLEAR |=> !O_FAULT_CLEAR)
        else $error("fault clear pulse too long");
    AST_FC_RUN: assert property (O_FAULT_CLEAR |-> ##[0:2] O_RUN_MODE)
        else $error("no run after fault clear");
    AST_RUN_LED: assert property (O_RUN_MODE && $past(O_RUN_MODE) |-> O_RUN_LED)
        else $error("run lamp not steady in run");
    AST_RUN_SW: assert property ($rose(O_RUN_MODE) |-> I_SW_RUN)
        else $error("run entered with switch in stop");
    AST_STRAY: assert property (stray_ff <= STRAY_MAX)
        else $error("run kept too long after stop");
    AST_NET_LEN: assert property ($fell(O_NET_RESET) |-> net_ff >= NET_MIN && net_ff <= NET_MAX)
        else $error("network reset length wrong");
    AST_AMBER: assert property ($fell(O_NET_RESET) |-> ##[0:1] O_NET_LED_AMBER)
        else $error("amber lamp missing");
    AST_GREEN: assert property ($fell(O_NET_LED_AMBER) |-> ##[0:1] O_NET_LED_GREEN)
        else $error("green lamp missing");
    AST_NET_AT_REL: assert property ($rose(O_NET_RESET) |-> !I_RESTART_BTN)
        else $error("network reset while still pressed");
    AST_PORT_QUIET: assert property ($changed(O_PORT_LOCAL_MGR) |-> !O_NET_RESET)
        else $error("port toggle with network reset");
endmodule
bind mode_switch_ctl mode_switch_ctl_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_SW_RUN(I_SW_RUN), .I_RESTART_BTN(I_RESTART_BTN),
    .O_RUN_MODE(O_RUN_MODE), .O_RUN_LED(O_RUN_LED), .O_FAULT_CLEAR(O_FAULT_CLEAR),
    .O_MEM_WRITE_BLOCK(O_MEM_WRITE_BLOCK), .O_FORCE_BLOCK(O_FORCE_BLOCK), .O_NET_RESET(O_NET_RESET),
    .O_NET_LED_AMBER(O_NET_LED_AMBER), .O_NET_LED_GREEN(O_NET_LED_GREEN), .O_PORT_LOCAL_MGR(O_PORT_LOCAL_MGR)
);
`default_nettype wire

// [dv/operator_model.sv]
`default_nettype none
module operator_model #(
    parameter int unsigned MS_CYCLES = 4
) (
    input wire logic i_clk,
    output logic o_sw_run,
    output logic o_btn
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sw_run = 1'b0;
        o_btn = 1'b0;
    end
    task automatic hold_ms(input int unsigned n);
        repeat (n * MS_CYCLES) @(posedge i_clk);
    endtask
    // Switch has no bounce here, so hold times are exact
    task automatic set_switch(input logic run, input int unsigned n);
        @(posedge i_clk);
        o_sw_run <= run;
        hold_ms(n);
    endtask
    task automatic press(input int unsigned n);
        @(posedge i_clk);
        o_btn <= 1'b1;
        hold_ms(n);
        o_btn <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned MS = 4;
    logic clk, arst_n, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic sw, btn, run_mode, run_led, fc, mem_blk, frc_blk, net_rst, amber, green, port_lm, irq;
    int failures, check_count, led_rises, fc_pulses, net_rises;
    operator_model #(.MS_CYCLES(MS)) op_u (.i_clk(clk), .o_sw_run(sw), .o_btn(btn));
    mode_switch_ctl #(.MS_CYCLES(MS)) dut_u (
        .I_REF_CLK(clk), .I_ARST_N(arst_n), .I_SW_RUN(sw), .I_RESTART_BTN(btn),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .O_RUN_MODE(run_mode), .O_RUN_LED(run_led), .O_FAULT_CLEAR(fc),
        .O_MEM_WRITE_BLOCK(mem_blk), .O_FORCE_BLOCK(frc_blk), .O_NET_RESET(net_rst),
        .O_NET_LED_AMBER(amber), .O_NET_LED_GREEN(green), .O_PORT_LOCAL_MGR(port_lm), .O_IRQ(irq)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge run_led) led_rises++;
    always @(posedge fc) fc_pulses++;
    always @(posedge net_rst) net_rises++;
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic ms(input int unsigned n);
        repeat (n * MS) @(posedge clk);
    endtask
    task automatic lost(input logic hit);
        if (!hit) begin
            failures++;
            $display("ERROR %0t bus answer missing", $time);
        end
    endtask
    // Readies are sampled mid-cycle; they only move on rising edges
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = mode_ctl_pkg::RESP_OKAY);
        logic ah, wh, bh;
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ah = awv & awrdy;
            wh = wv & wrdy;
            bh = bvalid;
            if (bh) chk({30'h0, bresp}, {30'h0, er});
            @(posedge clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (bh) bready <= 1'b0;
            n++;
        end while (bh !== 1'b1 && n < 1000);
        lost(bh);
        // Return mid-cycle so outputs registered off the write have settled
        @(negedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er = mode_ctl_pkg::RESP_OKAY);
        logic ah, rh;
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ah = arv & arrdy;
            rh = rvalid;
            if (rh) chk(rdata, ed);
            if (rh) chk({30'h0, rresp}, {30'h0, er});
            @(posedge clk);
            if (ah) arv <= 1'b0;
            if (rh) rready <= 1'b0;
            n++;
        end while (rh !== 1'b1 && n < 1000);
        lost(rh);
        @(negedge clk);
    endtask
    initial begin
        repeat (97000) @(posedge clk);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        arst_n = 1'b0;
        {awv, wv, bready, arv, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(mode_ctl_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(mode_ctl_pkg::ADDR_STATUS, 32'h0000_0021);
        rd(32'h0000_0020, 32'h0, mode_ctl_pkg::RESP_SLVERR);
        wr(32'h0000_0020, 32'hFF, mode_ctl_pkg::RESP_SLVERR);
        op_u.press(100);
        ms(15);
        chk1(net_rst, 1'b1);
        ms(100);
        chk1(amber, 1'b1);
        ms(250);
        chk1(green, 1'b1);
        ms(300);
        chk({green, amber, net_rst, irq}, 4'h0);
        rd(mode_ctl_pkg::ADDR_IRQ_STAT, 32'h2);
        wr(mode_ctl_pkg::ADDR_IRQ_EN, 32'hF);
        chk1(irq, 1'b1);
        wr(mode_ctl_pkg::ADDR_IRQ_CLR, 32'h2);
        chk1(irq, 1'b0);
        rd(mode_ctl_pkg::ADDR_IRQ_CLR, 32'h0);
        wr(mode_ctl_pkg::ADDR_CTRL, 32'h13);
        chk({mem_blk, frc_blk}, 2'h3);
        op_u.set_switch(1'b1, 15);
        chk({run_mode, mem_blk}, 2'h2);
        rd(mode_ctl_pkg::ADDR_CTRL, 32'h13);
        wr(mode_ctl_pkg::ADDR_CTRL, 32'h12);
        ms(2);
        chk1(run_mode, 1'b0);
        op_u.set_switch(1'b0, 15);
        wr(mode_ctl_pkg::ADDR_CTRL, 32'h09);
        led_rises = 0;
        op_u.set_switch(1'b1, 1000);
        chk({run_mode, 1'(led_rises >= 2)}, 2'h1);
        ms(4300);
        chk({run_mode, run_led}, 2'h0);
        rd(mode_ctl_pkg::ADDR_STATUS, 32'h30);
        rd(mode_ctl_pkg::ADDR_CTRL, 32'h09);
        rd(mode_ctl_pkg::ADDR_IRQ_STAT, 32'h8);
        wr(mode_ctl_pkg::ADDR_IRQ_CLR, 32'hF);
        op_u.set_switch(1'b0, 20);
        op_u.set_switch(1'b1, 600);
        op_u.set_switch(1'b0, 600);
        op_u.set_switch(1'b1, 20);
        chk({run_mode, run_led}, 2'h3);
        chk(fc_pulses, 32'h1);
        rd(mode_ctl_pkg::ADDR_CTRL, 32'h01);
        rd(mode_ctl_pkg::ADDR_IRQ_STAT, 32'h1);
        wr(mode_ctl_pkg::ADDR_IRQ_CLR, 32'hF);
        op_u.set_switch(1'b0, 20);
        op_u.press(5100);
        ms(20);
        chk1(port_lm, 1'b1);
        rd(mode_ctl_pkg::ADDR_IRQ_STAT, 32'h4);
        op_u.press(5100);
        ms(20);
        chk1(port_lm, 1'b0);
        wr(mode_ctl_pkg::ADDR_CTRL, 32'h05);
        chk1(port_lm, 1'b1);
        op_u.press(5100);
        ms(20);
        wr(mode_ctl_pkg::ADDR_CTRL, 32'h01);
        chk1(port_lm, 1'b0);
        chk(net_rises, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
